// File: hdl/fets_ctrl.sv
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/10ps
module fets_ctrl (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  output fets_pkg::fets_pins_s fl_pins_o,
  input wire logic [7:0] fl_dq_i,
  input wire logic fl_ready_i,
  output logic fl_reset_n_o
);
  fets_pkg::fets_phase_e ph_r, ph_nxt; // Flash cycle phase
  logic [2:0] cnt_r, cnt_nxt; // Strobe width counter
  fets_pkg::fets_pins_s pins_r, pins_nxt; // Registered flash pins
  logic [7:0] rdat_r, rdat_nxt; // Byte sampled at strobe end
  logic acc_go; // Start a flash cycle
  logic acc_wr; // Started cycle is a write
  logic [20:0] acc_addr; // Address of started cycle
  logic [7:0] acc_data; // Data of started write
  logic acc_done; // Cycle in its hold phase
  fets_pkg::fets_state_e st_r, st_nxt; // Control state
  logic [2:0] op_r, op_nxt; // Operation in progress
  logic [2:0] idx_r, idx_nxt; // Step within a command sequence
  logic [20:0] addr_r, addr_nxt; // Target and polling address
  logic [7:0] wdata_r, wdata_nxt; // Byte to program
  logic [7:0] first_r, first_nxt; // First read of a toggle pair
  logic recheck_r, recheck_nxt; // Timeout seen, one more pair due
  logic fail_r, fail_nxt; // Operation ended in failure
  logic window_r, window_nxt; // Sector erase window believed open
  logic timer_r, timer_nxt; // Last erase timer bit read
  logic [7:0] last_r, last_nxt; // Last status byte read
  logic [4:0] irq_stat_r, irq_stat_nxt; // Sticky events
  logic [4:0] irq_en_r, irq_en_nxt; // Event enables
  logic [4:0] ev; // Events raised this cycle
  logic [4:0] irq_clr; // Clear strobes from software
  logic ack_r, ack_nxt; // Avalon answer cycle
  logic [31:0] rd_r, rd_nxt; // Avalon read data
  logic wr_eff; // Avalon write takes effect now
  logic tgl; // Toggle bit differs between pair reads
  logic tout; // Timeout flag seen in pair
  fets_pkg::fets_step_s step; // Current sequence step

  // Address, data and end mark of each command sequence step
  function automatic fets_pkg::fets_step_s seq_step(input logic [2:0] op, input logic [2:0] idx,
                                                    input logic [20:0] a, input logic [7:0] d);
    fets_pkg::fets_step_s s;
    s.addr = fets_pkg::UNL_A1;
    s.data = fets_pkg::UNL_D1;
    s.last = 1'b0;
    case (op)
      fets_pkg::OP_SUSP: begin
        s = '{a, fets_pkg::CD_SUSP, 1'b1};
      end
      fets_pkg::OP_RESUME: begin
        s = '{a, fets_pkg::CD_RESUME, 1'b1};
      end
      fets_pkg::OP_RESET: begin
        s = '{a, fets_pkg::CD_RESET, 1'b1};
      end
      // Added sector is a single write, which restarts the device window
      fets_pkg::OP_ADD: begin
        s = '{a, fets_pkg::CD_SECT, 1'b1};
      end
      default: begin
        case (idx)
          3'h1, 3'h4: begin
            s = '{fets_pkg::UNL_A2, fets_pkg::UNL_D2, 1'b0};
          end
          3'h2: begin
            s.data = (op == fets_pkg::OP_PROG) ? fets_pkg::CD_PROG : fets_pkg::CD_ERASE;
          end
          3'h3: begin
            if (op == fets_pkg::OP_PROG) begin
              s = '{a, d, 1'b1};
            end
          end
          3'h5: begin
            // Chip erase ends on its own code and never reads the timer
            s = (op == fets_pkg::OP_CHIP) ? '{fets_pkg::UNL_A1, fets_pkg::CD_CHIP, 1'b1}
                                          : '{a, fets_pkg::CD_SECT, 1'b1};
          end
          default: begin
            s.last = 1'b0;
          end
        endcase
      end
    endcase
    return s;
  endfunction

  assign step = seq_step(op_r, idx_r, addr_r, wdata_r);
  assign acc_done = (ph_r == fets_pkg::PH_HOLD);

  // Flash cycle engine: setup, strobe held for the access time, hold
  always_comb begin
    ph_nxt = ph_r;
    cnt_nxt = cnt_r;
    pins_nxt = pins_r;
    rdat_nxt = rdat_r;
    case (ph_r)
      fets_pkg::PH_IDLE: begin
        if (acc_go) begin
          ph_nxt = fets_pkg::PH_SETUP;
          pins_nxt = '{acc_addr, acc_data, acc_wr, 1'b0, 1'b1, 1'b1};
        end
      end
      fets_pkg::PH_SETUP: begin
        ph_nxt = fets_pkg::PH_STROBE;
        cnt_nxt = fets_pkg::STROBE_CNT;
        pins_nxt.oe_n = pins_r.dq_oe;
        pins_nxt.we_n = ~pins_r.dq_oe;
      end
      fets_pkg::PH_STROBE: begin
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h1) begin
          // Sample before lifting the strobe; device data is stable here
          ph_nxt = fets_pkg::PH_HOLD;
          rdat_nxt = fl_dq_i;
          pins_nxt.oe_n = 1'b1;
          pins_nxt.we_n = 1'b1;
        end
      end
      default: begin
        // Hold keeps data and address one cycle past the strobe
        ph_nxt = fets_pkg::PH_IDLE;
        pins_nxt.ce_n = 1'b1;
        pins_nxt.dq_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ph_r <= fets_pkg::PH_IDLE;
      cnt_r <= 3'h0;
      pins_r <= '{fets_pkg::ADDR_RST, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1};
      rdat_r <= 8'h00;
    end else if (ce_i) begin
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      pins_r <= pins_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wr_eff = avs_write_i & ack_r;
  assign tgl = rdat_r[fets_pkg::BIT_TOGGLE] ^ first_r[fets_pkg::BIT_TOGGLE];
  assign tout = rdat_r[fets_pkg::BIT_TIMEOUT] | first_r[fets_pkg::BIT_TIMEOUT];

  // Sticky event bits; a new event wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < fets_pkg::IRQ_W; gi++) begin : g_irq
      assign irq_clr[gi] = wr_eff & (avs_address_i == fets_pkg::OFS_IRQ_CLR) & avs_writedata_i[gi];
      assign irq_stat_nxt[gi] = ev[gi] | (irq_stat_r[gi] & ~irq_clr[gi]);
    end
  endgenerate

  // Control sequencer and software registers
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    idx_nxt = idx_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    first_nxt = first_r;
    recheck_nxt = recheck_r;
    fail_nxt = fail_r;
    window_nxt = window_r;
    timer_nxt = timer_r;
    last_nxt = last_r;
    irq_en_nxt = irq_en_r;
    ev = 5'h00;
    acc_go = 1'b0;
    acc_wr = 1'b0;
    acc_addr = addr_r;
    acc_data = step.data;
    ack_nxt = (avs_read_i | avs_write_i) & ~ack_r;
    rd_nxt = rd_r;
    // Read data is built in the wait cycle and stands at the answer edge
    if (avs_read_i & ~ack_r) begin
      case (avs_address_i)
        fets_pkg::OFS_CMD: rd_nxt = {29'h0, op_r};
        fets_pkg::OFS_ADDR: rd_nxt = {11'h0, addr_r};
        fets_pkg::OFS_WDATA: rd_nxt = {24'h0, wdata_r};
        fets_pkg::OFS_STAT: rd_nxt = {16'h0, last_r, 3'h0, fl_ready_i, window_r, fail_r, timer_r,
                                       st_r != fets_pkg::S_IDLE};
        fets_pkg::OFS_IRQ_STAT: rd_nxt = {27'h0, irq_stat_r};
        fets_pkg::OFS_IRQ_EN: rd_nxt = {27'h0, irq_en_r};
        default: rd_nxt = 32'h0;
      endcase
    end
    // Parameter registers change only while idle
    if (wr_eff & (st_r == fets_pkg::S_IDLE)) begin
      if (avs_address_i == fets_pkg::OFS_ADDR) begin
        addr_nxt = avs_writedata_i[20:0];
      end
      if (avs_address_i == fets_pkg::OFS_WDATA) begin
        wdata_nxt = avs_writedata_i[7:0];
      end
    end
    if (wr_eff & (avs_address_i == fets_pkg::OFS_IRQ_EN)) begin
      irq_en_nxt = avs_writedata_i[4:0];
    end
    case (st_r)
      fets_pkg::S_IDLE: begin
        if (wr_eff & (avs_address_i == fets_pkg::OFS_CMD)) begin
          op_nxt = avs_writedata_i[2:0];
          idx_nxt = 3'h0;
          recheck_nxt = 1'b0;
          fail_nxt = 1'b0;
          if (avs_writedata_i[2:0] == fets_pkg::OP_ADD) begin
            st_nxt = fets_pkg::S_PRE;
          end else if (avs_writedata_i[2:0] == fets_pkg::OP_WAIT) begin
            st_nxt = fets_pkg::S_POLL1;
          end else begin
            st_nxt = fets_pkg::S_SEQ;
          end
        end
      end
      fets_pkg::S_SEQ: begin
        acc_go = ~acc_done;
        acc_wr = 1'b1;
        acc_addr = step.addr;
        if (acc_done) begin
          idx_nxt = idx_r + 3'h1;
          if (step.last) begin
            case (op_r)
              fets_pkg::OP_ADD: st_nxt = fets_pkg::S_POST;
              fets_pkg::OP_RESET: begin
                st_nxt = fets_pkg::S_IDLE;
                window_nxt = 1'b0;
                ev[fets_pkg::IRQ_DONE] = 1'b1;
              end
              // Sector erase first proves acceptance by toggling
              default: st_nxt = fets_pkg::S_POLL1;
            endcase
          end
        end
      end
      fets_pkg::S_POLL1: begin
        acc_go = ~acc_done;
        if (acc_done) begin
          first_nxt = rdat_r;
          last_nxt = rdat_r;
          st_nxt = fets_pkg::S_POLL2;
        end
      end
      fets_pkg::S_POLL2: begin
        acc_go = ~acc_done;
        if (acc_done) begin
          last_nxt = rdat_r;
          if (!tgl) begin
            // Toggling stopped: finished, suspended or nothing to erase
            st_nxt = fets_pkg::S_IDLE;
            window_nxt = 1'b0;
            ev[fets_pkg::IRQ_DONE] = 1'b1;
          end else if (op_r == fets_pkg::OP_SECT) begin
            st_nxt = fets_pkg::S_TMR;
          end else if (recheck_r) begin
            st_nxt = fets_pkg::S_RST;
            fail_nxt = 1'b1;
            ev[fets_pkg::IRQ_FAIL] = 1'b1;
          end else begin
            // A timeout may coincide with the last toggle, so read a fresh pair
            recheck_nxt = tout;
            st_nxt = fets_pkg::S_POLL1;
          end
        end
      end
      fets_pkg::S_TMR, fets_pkg::S_PRE, fets_pkg::S_POST: begin
        acc_go = ~acc_done;
        if (acc_done) begin
          last_nxt = rdat_r;
          timer_nxt = rdat_r[fets_pkg::BIT_TIMER];
          window_nxt = ~rdat_r[fets_pkg::BIT_TIMER];
          st_nxt = fets_pkg::S_IDLE;
          if (rdat_r[fets_pkg::BIT_TIMER]) begin
            ev[fets_pkg::IRQ_ERASE_GO] = 1'b1;
          end
          if (st_r == fets_pkg::S_PRE) begin
            if (rdat_r[fets_pkg::BIT_TIMER]) begin
              // Window already shut: the added sector would be ignored
              ev[fets_pkg::IRQ_ADD_LOST] = 1'b1;
              ev[fets_pkg::IRQ_DONE] = 1'b1;
            end else begin
              st_nxt = fets_pkg::S_SEQ;
            end
          end else begin
            ev[fets_pkg::IRQ_ADD_LOST] = (st_r == fets_pkg::S_POST) & rdat_r[fets_pkg::BIT_TIMER];
            ev[fets_pkg::IRQ_DONE] = 1'b1;
          end
        end
      end
      fets_pkg::S_RST: begin
        acc_go = ~acc_done;
        acc_wr = 1'b1;
        acc_data = fets_pkg::CD_RESET;
        if (acc_done) begin
          st_nxt = fets_pkg::S_IDLE;
          window_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = fets_pkg::S_IDLE;
      end
    endcase
    // Orders arriving while busy are dropped and reported
    if (wr_eff & (avs_address_i == fets_pkg::OFS_CMD) & (st_r != fets_pkg::S_IDLE)) begin
      ev[fets_pkg::IRQ_REFUSED] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r <= fets_pkg::S_IDLE;
      op_r <= fets_pkg::OP_WAIT;
      idx_r <= 3'h0;
      addr_r <= fets_pkg::ADDR_RST;
      wdata_r <= fets_pkg::WDATA_RST;
      first_r <= 8'h00;
      recheck_r <= 1'b0;
      fail_r <= 1'b0;
      window_r <= 1'b0;
      timer_r <= 1'b0;
      last_r <= 8'h00;
      irq_stat_r <= 5'h00;
      irq_en_r <= fets_pkg::IRQ_EN_RST;
      ack_r <= 1'b0;
      rd_r <= 32'h0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      idx_r <= idx_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      first_r <= first_nxt;
      recheck_r <= recheck_nxt;
      fail_r <= fail_nxt;
      window_r <= window_nxt;
      timer_r <= timer_nxt;
      last_r <= last_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_en_r <= irq_en_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o = rd_r;
  assign irq_o = |(irq_stat_r & irq_en_r);
  assign fl_pins_o = pins_r;
  // The controller never pulses the device reset pin
  assign fl_reset_n_o = 1'b1;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sect_accept_first_a: assert property ((st_r == fets_pkg::S_SEQ) && acc_done && step.last && (op_r == fets_pkg::OP_SECT)
    |=> (st_r == fets_pkg::S_POLL1) ##[1:12] (st_r == fets_pkg::S_POLL2)) else $error("sector erase not checked first");
  add_pre_check_a: assert property ((st_r == fets_pkg::S_IDLE) && wr_eff && (avs_address_i == fets_pkg::OFS_CMD)
    && (avs_writedata_i[2:0] == fets_pkg::OP_ADD) |=> (st_r == fets_pkg::S_PRE)) else $error("no timer read before add");
  add_post_read_a: assert property ((st_r == fets_pkg::S_SEQ) && acc_done && (op_r == fets_pkg::OP_ADD)
    |-> ##[2:8] !fl_pins_o.oe_n) else $error("timer bit not read after add");
  poll_valid_addr_a: assert property (((st_r == fets_pkg::S_POLL1) || (st_r == fets_pkg::S_POLL2)) && !fl_pins_o.oe_n
    |-> (fl_pins_o.addr == addr_r)) else $error("status polled at wrong address");
  fail_after_recheck_a: assert property ($rose(fail_r) |-> $past(recheck_r) && $past(tgl)) else $error("fail without recheck");
  reset_after_fail_a: assert property ($rose(fail_r) |-> ##[1:8] (!fl_pins_o.we_n && fl_pins_o.dq == fets_pkg::CD_RESET))
    else $error("reset command missing after fail");
  strobe_excl_a: assert property (!(!fl_pins_o.we_n && !fl_pins_o.oe_n) && (fl_pins_o.dq_oe || fl_pins_o.we_n))
    else $error("write and read strobe overlap");
  cover_prog_c: cover property ((op_r == fets_pkg::OP_PROG) && ev[fets_pkg::IRQ_DONE]);
  cover_fail_c: cover property (ev[fets_pkg::IRQ_FAIL]);
  cover_add_lost_c: cover property (ev[fets_pkg::IRQ_ADD_LOST]);
  cover_window_c: cover property ((st_r == fets_pkg::S_TMR) && acc_done && !rdat_r[fets_pkg::BIT_TIMER]);
endmodule // fets_ctrl

// File: hdl/fets_pkg.sv
package fets_pkg;
  // Clock rate and flash strobe timing
  localparam int unsigned CLK_NS = 100;
  // Strobe width covers the slowest access grade
  localparam int unsigned STROBE_NS = 150;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] STROBE_CNT = 3'(STROBE_CYC);

  // Register byte offsets on the Avalon slave
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_ADDR = 5'h04;
  localparam logic [4:0] OFS_WDATA = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFS_IRQ_CLR = 5'h14;
  localparam logic [4:0] OFS_IRQ_EN = 5'h18;

  // Operations that software may order
  localparam logic [2:0] OP_WAIT = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_SECT = 3'h2;
  localparam logic [2:0] OP_ADD = 3'h3;
  localparam logic [2:0] OP_CHIP = 3'h4;
  localparam logic [2:0] OP_SUSP = 3'h5;
  localparam logic [2:0] OP_RESUME = 3'h6;
  localparam logic [2:0] OP_RESET = 3'h7;

  // Flash command cycle addresses and data
  localparam logic [20:0] UNL_A1 = 21'h000555;
  localparam logic [20:0] UNL_A2 = 21'h0002AA;
  localparam logic [7:0] UNL_D1 = 8'hAA;
  localparam logic [7:0] UNL_D2 = 8'h55;
  localparam logic [7:0] CD_PROG = 8'hA0;
  localparam logic [7:0] CD_ERASE = 8'h80;
  localparam logic [7:0] CD_CHIP = 8'h10;
  localparam logic [7:0] CD_SECT = 8'h30;
  localparam logic [7:0] CD_SUSP = 8'hB0;
  localparam logic [7:0] CD_RESUME = 8'h30;
  localparam logic [7:0] CD_RESET = 8'hF0;

  // Status bit positions on the flash data bus
  localparam int unsigned BIT_TOGGLE = 6;
  localparam int unsigned BIT_TIMEOUT = 5;
  localparam int unsigned BIT_TIMER = 3;

  // Interrupt event bits
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_FAIL = 1;
  localparam int unsigned IRQ_ERASE_GO = 2;
  localparam int unsigned IRQ_ADD_LOST = 3;
  localparam int unsigned IRQ_REFUSED = 4;

  // Values after reset
  localparam logic [20:0] ADDR_RST = 21'h000000;
  localparam logic [7:0] WDATA_RST = 8'h00;
  localparam logic [4:0] IRQ_EN_RST = 5'h00;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_SEQ = 4'h1,
    S_POLL1 = 4'h2,
    S_POLL2 = 4'h3,
    S_TMR = 4'h4,
    S_PRE = 4'h5,
    S_POST = 4'h6,
    S_RST = 4'h7
  } fets_state_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_SETUP = 2'h1,
    PH_STROBE = 2'h2,
    PH_HOLD = 2'h3
  } fets_phase_e;

  // Flash pin group driven by the controller
  typedef struct packed {
    logic [20:0] addr;
    logic [7:0] dq;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fets_pins_s;

  // One write cycle of a command sequence
  typedef struct packed {
    logic [20:0] addr;
    logic [7:0] data;
    logic last;
  } fets_step_s;
endpackage

// File: sim/fets_flash_model.sv
`timescale 1ns/10ps
// Behavioural flash device at the controller's pins; counts are shortened
module fets_flash_model #(
  parameter int WIN_CYC = 150, // Acceptance window, shortened
  parameter int OP_CYC = 300 // Program or erase length, shortened
) (
  input wire logic clk_i,
  input wire fets_pkg::fets_pins_s pins_i,
  input wire logic fail_i,
  output logic [7:0] dq_o,
  output logic ready_o,
  output int resets_o
);
  typedef enum logic [2:0] {F_IDLE, F_PROG, F_WIN, F_ERASE, F_SUSP, F_CHIP} fets_fmode_e;
  fets_fmode_e mode = F_IDLE; // Current device activity
  int seq = 0; // Unlock cycles seen so far
  int cnt = 0; // Cycles left in window or operation
  logic tog = 1'b0, tog2 = 1'b0, tmo = 1'b0, we_q = 1'b1, oe_q = 1'b1;
  logic [7:0] wbit = 8'h00, cur, last = 8'h00;
  initial resets_o = 0;
  // Status byte chosen by activity
  always_comb begin
    case (mode)
      F_PROG: cur = {~wbit[7], tog, tmo, 5'h00};
      F_WIN: cur = {1'b0, tog, 1'b0, 1'b0, 1'b0, tog2, 2'h0};
      F_ERASE: cur = {1'b0, tog, tmo, 1'b0, 1'b1, tog2, 2'h0};
      F_CHIP: cur = {1'b0, tog, tmo, 1'b0, 1'b0, tog2, 2'h0};
      F_SUSP: cur = {1'b1, tog, 1'b0, 1'b0, 1'b0, tog2, 2'h0};
      default: cur = 8'hFF;
    endcase
  end
  // A released bus shows the inverse of its last value, never a stale copy
  assign dq_o = pins_i.oe_n ? ~last : cur;
  assign ready_o = !(mode inside {F_PROG, F_ERASE, F_CHIP});
  // Timers, toggles and command decode
  always @(posedge clk_i) begin
    we_q <= pins_i.we_n;
    oe_q <= pins_i.oe_n;
    if (!pins_i.oe_n) last <= cur;
    // End of each read flips the toggle bits while active, except that tog holds in suspend
    if (pins_i.oe_n && !oe_q && mode != F_IDLE) begin
      if (mode != F_SUSP) tog <= ~tog;
      tog2 <= ~tog2;
    end
    if (cnt > 0 && mode != F_SUSP) cnt <= cnt - 1;
    else case (mode)
      F_WIN: begin
        mode <= F_ERASE;
        cnt <= OP_CYC;
      end
      F_PROG, F_ERASE, F_CHIP: if (fail_i) tmo <= 1'b1; else mode <= F_IDLE;
      default: ;
    endcase
    // A write cycle ends at the rising write strobe
    if (pins_i.we_n && !we_q) begin
      if (pins_i.dq == 8'hF0 && (mode != F_ERASE || tmo)) begin
        mode <= F_IDLE;
        tmo <= 1'b0;
        seq <= 0;
        resets_o <= resets_o + 1;
      end else if (mode == F_ERASE) begin
        if (pins_i.dq == 8'hB0) mode <= F_SUSP;
      end else if (mode == F_WIN && pins_i.dq == 8'h30) cnt <= WIN_CYC;
      else if (mode == F_SUSP && pins_i.dq == 8'h30) mode <= F_ERASE;
      else if (seq == 3) begin
        mode <= F_PROG;
        wbit <= pins_i.dq;
        cnt <= OP_CYC;
        seq <= 0;
      end else if (seq == 6) begin
        mode <= (pins_i.dq == 8'h10) ? F_CHIP : F_WIN;
        cnt <= (pins_i.dq == 8'h10) ? OP_CYC : WIN_CYC;
        seq <= 0;
      end else if (pins_i.dq == 8'hAA) seq <= (seq == 4) ? 5 : 1;
      else if (pins_i.dq == 8'h55) seq <= seq + 1;
      else if (pins_i.dq == 8'hA0 && seq == 2) seq <= 3;
      else if (pins_i.dq == 8'h80 && seq == 2) seq <= 4;
      else seq <= 0;
    end
  end
endmodule // fets_flash_model

// File: sim/fets_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench: Avalon master, flash model, expected event bits
module fets_tb_top;
  logic clk_i = 1'b0, reset_n_i = 1'b0, rd = 1'b0, wr = 1'b0, fail = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, got, a, d;
  logic wreq, irq, frdy, frst_n;
  fets_pkg::fets_pins_s pins;
  logic [7:0] fdq;
  int resets, i, err_total = 0, checks_done = 0, seed = 73;
  int exp_irq; // Expected sticky event bits
  fets_ctrl dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .irq_o(irq), .fl_pins_o(pins), .fl_dq_i(fdq),
    .fl_ready_i(frdy), .fl_reset_n_o(frst_n));
  fets_flash_model flash (.clk_i(clk_i), .pins_i(pins), .fail_i(fail), .dq_o(fdq),
    .ready_o(frdy), .resets_o(resets));
  // Free-running 10 MHz clock
  initial forever #50 clk_i = ~clk_i;
  task finish_test;
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One Avalon access; held until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] ad, input logic [31:0] dt, output logic [31:0] q);
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    adr <= ad;
    wdat <= dt;
    do @(posedge clk_i); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task wreg(input logic [4:0] ad, input logic [31:0] dt);
    bus(1'b1, ad, dt, got);
    // Let register outputs settle past the edge that took the write
    #1;
  endtask
  task rd_chk(input string nm, input logic [4:0] ad, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, ad, 32'h0, got);
    chk(nm, e & m, got & m);
  endtask
  // Poll the busy flag under a bounded count
  task wait_idle;
    int k;
    k = 0;
    do begin
      bus(1'b0, fets_pkg::OFS_STAT, 32'h0, got);
      k++;
    end while (got[0] !== 1'b0 && k < 2000);
    chk("busy", 32'h0, {31'h0, got[0]});
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk("addr_rst", fets_pkg::OFS_ADDR, 32'hFFFFFFFF, {11'h0, fets_pkg::ADDR_RST});
    rd_chk("wdata_rst", fets_pkg::OFS_WDATA, 32'hFFFFFFFF, {24'h0, fets_pkg::WDATA_RST});
    rd_chk("irq_en_rst", fets_pkg::OFS_IRQ_EN, 32'hFFFFFFFF, {27'h0, fets_pkg::IRQ_EN_RST});
    rd_chk("unmapped", 5'h1C, 32'hFFFFFFFF, 32'h0);
    chk("irq_idle", 32'h0, {31'h0, irq});
    wreg(fets_pkg::OFS_IRQ_EN, 32'h1F);
    // Programs with random data, the last one timing out
    for (i = 0; i < 3; i++) begin
      fail <= (i == 2);
      a = $random(seed);
      d = $random(seed);
      wreg(fets_pkg::OFS_ADDR, {11'h0, a[20:0]});
      wreg(fets_pkg::OFS_WDATA, {24'h0, d[7:0]});
      wreg(fets_pkg::OFS_CMD, 32'(fets_pkg::OP_PROG));
      wreg(fets_pkg::OFS_CMD, 32'(fets_pkg::OP_PROG));
      repeat (25) @(posedge clk_i);
      chk("ready_prog", 32'h0, {31'h0, frdy});
      wait_idle();
      exp_irq = (1 << fets_pkg::IRQ_REFUSED) | (1 << ((i == 2) ? fets_pkg::IRQ_FAIL : fets_pkg::IRQ_DONE));
      rd_chk("irq_stat", fets_pkg::OFS_IRQ_STAT, (i == 2) ? 32'h12 : 32'h1F, exp_irq);
      chk("irq_level", 32'h1, {31'h0, irq});
      wreg(fets_pkg::OFS_IRQ_CLR, 32'h1F);
      chk("irq_clear", 32'h0, {31'h0, irq});
    end
    chk("reset_cmds", 32'(1), 32'(resets));
    fail <= 1'b0;
    // Sector erase, two timely additions, one late addition
    wreg(fets_pkg::OFS_ADDR, 32'h0);
    wreg(fets_pkg::OFS_CMD, 32'(fets_pkg::OP_SECT));
    wait_idle();
    rd_chk("window_open", fets_pkg::OFS_STAT, 32'hA, 32'h8);
    for (i = 0; i < 2; i++) begin
      repeat (60) @(posedge clk_i);
      wreg(fets_pkg::OFS_CMD, 32'(fets_pkg::OP_ADD));
      wait_idle();
    end
    rd_chk("add_kept", fets_pkg::OFS_IRQ_STAT, 32'h8, 32'h0);
    repeat (200) @(posedge clk_i);
    wreg(fets_pkg::OFS_CMD, 32'(fets_pkg::OP_ADD));
    wait_idle();
    rd_chk("add_lost", fets_pkg::OFS_IRQ_STAT, 32'hC, 32'hC);
    chk("ready_erase", 32'h0, {31'h0, frdy});
    wreg(fets_pkg::OFS_CMD, 32'(fets_pkg::OP_SUSP));
    wait_idle();
    chk("ready_susp", 32'h1, {31'h0, frdy});
    wreg(fets_pkg::OFS_CMD, 32'(fets_pkg::OP_RESUME));
    wreg(fets_pkg::OFS_CMD, 32'(fets_pkg::OP_WAIT));
    wait_idle();
    rd_chk("erase_done", fets_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
    chk("ready_end", 32'h1, {31'h0, frdy});
    wreg(fets_pkg::OFS_IRQ_CLR, 32'h1F);
    // Chip erase has no window and leaves the timer bit from the sector erase in place
    wreg(fets_pkg::OFS_CMD, 32'(fets_pkg::OP_CHIP));
    wait_idle();
    rd_chk("chip_stat", fets_pkg::OFS_STAT, 32'hA, 32'h2);
    rd_chk("chip_done", fets_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
    wreg(fets_pkg::OFS_IRQ_EN, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wreg(fets_pkg::OFS_IRQ_EN, 32'h1F);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wreg(fets_pkg::OFS_CMD, 32'(fets_pkg::OP_RESET));
    wait_idle();
    chk("reset_cmds", 32'(2), 32'(resets));
    finish_test();
  end
  // Watchdog sized well beyond the expected run
  initial begin
    #(100 * 40000);
    err_total++;
    finish_test();
  end
endmodule // fets_tb_top
